// ==== inc/dbcw_pkg.sv ====
// Package of offsets, field positions and reset values for the debug/boot configuration word
package dbcw_pkg;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_WORD = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_STAGE = 4'h2;
  localparam logic [3:0] OFS_RELOAD = 4'h3;
  localparam int unsigned BIT_SWAP_DIS = 15;
  localparam int unsigned BIT_RSVD = 7;
  localparam int unsigned BIT_SCAN_EN = 6;
  localparam int unsigned BIT_CH_HI = 1;
  localparam int unsigned BIT_CH_LO = 0;
  // Implemented (programmable) positions; all others read as one
  localparam logic [23:0] IMPL_MASK = 24'h008043;
  localparam logic [23:0] ERASED_WORD = 24'hffffff;
  localparam logic [1:0] CH_PAIR_ONE = 2'h3;
  localparam logic [1:0] CH_PAIR_TWO = 2'h2;
  localparam logic [23:0] RDATA_RST = 24'h000000;
endpackage

// ==== rtl/dbcw_top.sv ====
// Debug and boot configuration word: latch after reset release, decode, register port
`timescale 1ns/1ps
module dbcw_top (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic [23:0] NVM_WORD,
  input wire logic [3:0] ADDR,
  input wire logic [23:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic SWAP_REQ,
  input wire logic DEBUG_CLK_IN,
  input wire logic DEBUG_DATA_IN,
  output logic [23:0] RDATA,
  output logic SWAP_INSTR_DISABLE,
  output logic SWAP_GRANT,
  output logic SCAN_PORT_ENABLE,
  output logic DEBUG_PAIR_ONE_SEL,
  output logic DEBUG_PAIR_TWO_SEL,
  output logic DEBUG_CLK_OUT,
  output logic DEBUG_DATA_OUT
);
  logic [23:0] word_ff;
  logic loaded_ff;
  logic [23:0] stage_ff;
  logic reload_ff;
  logic [23:0] nxt_word;
  logic [1:0] ch;

  // Word is captured from the array after reset release, never under reset
  always_comb begin
    nxt_word = (stage_ff & dbcw_pkg::IMPL_MASK) | ~dbcw_pkg::IMPL_MASK;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      loaded_ff <= 1'b0;
      stage_ff <= dbcw_pkg::ERASED_WORD;
    end else if (CLK_EN) begin
      if (!loaded_ff) begin
        stage_ff <= NVM_WORD;
        loaded_ff <= 1'b1;
      end else if (WR && ADDR == dbcw_pkg::OFS_STAGE) begin
        stage_ff <= WDATA;
      end
    end
  end

  // Image stays erased (all ones) until the first capture lands
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      word_ff <= dbcw_pkg::ERASED_WORD;
      reload_ff <= 1'b0;
    end else if (CLK_EN) begin
      reload_ff <= WR && ADDR == dbcw_pkg::OFS_RELOAD;
      if ((loaded_ff && !reload_ff && word_ff == dbcw_pkg::ERASED_WORD) || reload_ff) begin
        word_ff <= nxt_word;
      end
    end
  end

  assign ch = word_ff[dbcw_pkg::BIT_CH_HI:dbcw_pkg::BIT_CH_LO];

  // Bit 7 is deliberately not decoded anywhere
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      SWAP_INSTR_DISABLE <= 1'b1;
      SWAP_GRANT <= 1'b0;
      SCAN_PORT_ENABLE <= 1'b0;
      DEBUG_PAIR_ONE_SEL <= 1'b0;
      DEBUG_PAIR_TWO_SEL <= 1'b0;
      DEBUG_CLK_OUT <= 1'b0;
      DEBUG_DATA_OUT <= 1'b0;
    end else if (CLK_EN) begin
      SWAP_INSTR_DISABLE <= word_ff[dbcw_pkg::BIT_SWAP_DIS];
      SWAP_GRANT <= SWAP_REQ && !word_ff[dbcw_pkg::BIT_SWAP_DIS];
      SCAN_PORT_ENABLE <= word_ff[dbcw_pkg::BIT_SCAN_EN];
      DEBUG_PAIR_ONE_SEL <= (ch == dbcw_pkg::CH_PAIR_ONE);
      DEBUG_PAIR_TWO_SEL <= (ch == dbcw_pkg::CH_PAIR_TWO);
      // Undocumented codes route nowhere rather than guess a pair
      DEBUG_CLK_OUT <= (ch == dbcw_pkg::CH_PAIR_ONE || ch == dbcw_pkg::CH_PAIR_TWO) && DEBUG_CLK_IN;
      DEBUG_DATA_OUT <= (ch == dbcw_pkg::CH_PAIR_ONE || ch == dbcw_pkg::CH_PAIR_TWO) && DEBUG_DATA_IN;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RDATA <= dbcw_pkg::RDATA_RST;
    end else if (CLK_EN) begin
      if (RD) begin
        case (ADDR)
          dbcw_pkg::OFS_WORD: RDATA <= word_ff;
          dbcw_pkg::OFS_STATUS: RDATA <= {22'h000000, reload_ff, loaded_ff};
          dbcw_pkg::OFS_STAGE: RDATA <= stage_ff;
          default: RDATA <= 24'h000000;
        endcase
      end else begin
        RDATA <= 24'h000000;
      end
    end
  end

  a_unimpl_ones: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (word_ff | dbcw_pkg::IMPL_MASK) == dbcw_pkg::ERASED_WORD)
    else $error("unimplemented bit reads zero");
  a_read_word_ones: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CLK_EN && RD && ADDR == dbcw_pkg::OFS_WORD ##1 CLK_EN |-> RDATA[23:16] == 8'hff && RDATA[14:8] == 7'h7f)
    else $error("read of word shows zero in unimplemented bits");
  a_swap_blocked: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CLK_EN && word_ff[15] |=> !SWAP_GRANT)
    else $error("swap granted while disabled");
  a_swap_allowed: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CLK_EN && SWAP_REQ && !word_ff[15] |=> SWAP_GRANT && !SWAP_INSTR_DISABLE)
    else $error("swap refused while enabled");
  a_scan_follows: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CLK_EN |=> SCAN_PORT_ENABLE == $past(word_ff[6]))
    else $error("scan enable does not follow bit 6");
  a_pair_one: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CLK_EN && ch == 2'h3 |=> DEBUG_PAIR_ONE_SEL && !DEBUG_PAIR_TWO_SEL)
    else $error("code 11 not on pair one");
  a_pair_two: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CLK_EN && ch == 2'h2 |=> DEBUG_PAIR_TWO_SEL && !DEBUG_PAIR_ONE_SEL)
    else $error("code 10 not on pair two");
  a_pair_exclusive: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !(DEBUG_PAIR_ONE_SEL && DEBUG_PAIR_TWO_SEL))
    else $error("both pairs selected");
  a_load_once: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CLK_EN && !loaded_ff |=> loaded_ff && stage_ff == $past(NVM_WORD))
    else $error("word not captured after reset");

  c_swap_grant: cover property (@(posedge CORE_CLK) disable iff (!RST_N) SWAP_GRANT);
  c_scan_on: cover property (@(posedge CORE_CLK) disable iff (!RST_N) SCAN_PORT_ENABLE);
  c_pair_two: cover property (@(posedge CORE_CLK) disable iff (!RST_N) DEBUG_PAIR_TWO_SEL);
  c_reload: cover property (@(posedge CORE_CLK) disable iff (!RST_N) reload_ff ##1 loaded_ff);
endmodule

// ==== tb/dbcw_dbg_model.sv ====
// Behavioural debug tool driving the link pins
`timescale 1ns/1ps
module dbcw_dbg_model (
  input wire logic clk,
  input wire logic act,
  output logic dbg_clk,
  output logic dbg_dat
);
  initial begin
    dbg_clk = 1'b0;
    dbg_dat = 1'b0;
  end
  // Clock idles outside frames; data toggles each cycle while the clock is low and holds while it is high
  always @(posedge clk) begin
    if (act) begin
      dbg_clk <= ~dbg_clk;
    end
    dbg_dat <= ~dbg_dat ^ dbg_clk;
  end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the debug/boot configuration word
`timescale 1ns/1ps
module tb_top;
  logic CORE_CLK = 0, RST_N = 0, WR = 0, RD = 0, SWAP_REQ = 1, act = 0, e, ed, ce = 1;
  logic [3:0] ADDR = 4'h0;
  logic [23:0] WDATA = 24'h000000, RDATA;
  logic sdis, sgr, scan, p1, p2, dci, ddi, dco, ddo;
  int bad_count = 0, total_checks = 0;
  // Bit 7 kept at one in every programmed word
  logic [23:0] words [4] = '{24'h000080, 24'h008081, 24'h0000c2, 24'h0080c3};
  dbcw_top u_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(ce), .NVM_WORD(24'h0000c3),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .SWAP_REQ(SWAP_REQ), .DEBUG_CLK_IN(dci),
    .DEBUG_DATA_IN(ddi), .RDATA(RDATA), .SWAP_INSTR_DISABLE(sdis), .SWAP_GRANT(sgr),
    .SCAN_PORT_ENABLE(scan), .DEBUG_PAIR_ONE_SEL(p1), .DEBUG_PAIR_TWO_SEL(p2),
    .DEBUG_CLK_OUT(dco), .DEBUG_DATA_OUT(ddo));
  dbcw_dbg_model u_dbg (.clk(CORE_CLK), .act(act), .dbg_clk(dci), .dbg_dat(ddi));
  initial begin
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end
  task automatic chk(input logic [23:0] s, input logic [23:0] x);
    total_checks++;
    if (s !== x) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge CORE_CLK) {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge CORE_CLK) WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [23:0] x);
    @(posedge CORE_CLK) {ADDR, RD} <= {a, 1'b1};
    @(posedge CORE_CLK) RD <= 1'b0;
    #1 chk(RDATA, x);
  endtask
  task automatic t_load();
    rd(dbcw_pkg::OFS_WORD, 24'hff7fff);
    wr(dbcw_pkg::OFS_WORD, 24'h000000);
    rd(dbcw_pkg::OFS_WORD, 24'hff7fff);
    rd(4'h7, 24'h000000);
    // Frozen core must ignore a read and hold the idle zero
    @(posedge CORE_CLK) ce <= 1'b0;
    rd(dbcw_pkg::OFS_WORD, 24'h000000);
    @(posedge CORE_CLK) ce <= 1'b1;
  endtask
  task automatic t_word(input logic [23:0] w);
    wr(dbcw_pkg::OFS_STAGE, w);
    wr(dbcw_pkg::OFS_RELOAD, 24'h000000);
    repeat (4) @(posedge CORE_CLK);
    rd(dbcw_pkg::OFS_WORD, w | ~dbcw_pkg::IMPL_MASK);
    chk(sdis, w[15]);
    chk(sgr, !w[15]);
    chk(scan, w[6]);
    chk(p1, w[1:0] === dbcw_pkg::CH_PAIR_ONE);
    chk(p2, w[1:0] === dbcw_pkg::CH_PAIR_TWO);
    act <= 1'b1;
    repeat (2) begin
      @(negedge CORE_CLK) begin
        e = dci;
        ed = ddi;
      end
      @(posedge CORE_CLK) #1 chk(dco, e & w[1]);
      chk(ddo, ed & w[1]);
    end
    act <= 1'b0;
    // No request, no grant, whatever the swap bit says
    @(posedge CORE_CLK) SWAP_REQ <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    #1 chk(sgr, 1'b0);
    @(posedge CORE_CLK) SWAP_REQ <= 1'b1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    t_load();
    foreach (words[i]) t_word(words[i]);
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge CORE_CLK);
    bad_count++;
    report_and_stop();
  end
endmodule
